//--- rtl/general_io_ports.sv
// Four 8-bit general I/O ports with pull-high, wake-up and open-drain control
`timescale 1ns/1ps
// Function
// R1: Thirty-two bidirectional lines in four ports, each a data-memory register.
// R2: Input pins are sampled directly at read, not latched.
// R3: Written output data is held until software rewrites the latch.
// R4: Per-pin weak pull-high, effective only while the pin is an input.
// R5: Enabled port A falling edge wakes the device from power-down.
// R6: Misc upper nibble selects open drain for port A pins 0 to 3.
// R7: Misc lower nibble belongs to watchdog control, not ports.
// R8: Direction bit one means input, zero means CMOS output.
// R9: Reading an output pin returns its data latch.
// R10: Software disables external interrupts before using their pins as I/O.
// R11: Timer clock input pins keep their ordinary I/O function.
// R12: Divider output on port A pin 3 only when direction is output.
// R13: PWM on port D pins 0 to 3 only when direction is output.
// R14: Analog-selected port B pins lose their pull-high automatically.
// R15: Data latches and direction registers reset to all ones.
// R16: Bit set or clear reads whole port, modifies, writes back.
// R17: Open-drain output drives low for zero, floats for one.
// R18: Wake detect registers pins each clock, flags enabled falls in power-down.
module general_io_ports
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic reg_bitop_in,
  input wire logic reg_bitval_in,
  input wire logic [2:0] reg_bitsel_in,
  output logic [7:0] reg_rdata_out,
  // Shared pin functions
  input wire logic freq_divider_output_en_in,
  input wire logic freq_divider_output_in,
  input wire logic [3:0] pwm_en_in,
  input wire logic [3:0] pwm_in,
  input wire logic [7:0] converter_control_sel_in,
  input wire logic power_down_in,
  output logic wakeup_out,
  output logic [3:0] wdt_ctrl_out,
  // Pins
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n_out,
  output logic [31:0] pin_pull_out
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] data_q [PORT_COUNT];
  logic [7:0] data_d [PORT_COUNT];
  logic [7:0] dir_q [PORT_COUNT];
  logic [7:0] dir_d [PORT_COUNT];
  logic [7:0] pull_q [PORT_COUNT];
  logic [7:0] pull_d [PORT_COUNT];
  logic [7:0] wake_en_q;
  logic [7:0] wake_en_d;
  logic [7:0] misc_q;
  logic [7:0] misc_d;
  logic [7:0] pa_prev_q;
  logic [7:0] pa_prev_d;
  logic wake_q;
  logic wake_d;
  logic [7:0] port_read [PORT_COUNT];
  logic [7:0] read_mux;
  logic [7:0] wr_value;
  logic wr_any;
  pin_func_t func [PORT_COUNT];
  pin_drive_t drive [PORT_COUNT];

  // ****************************************************************
  // Pin-shared function routing
  // ****************************************************************

  // Only port A pin 3 and port D pins 0..3 carry output functions
  always_comb
  begin
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      func[p] = '{alt_en: 8'h00, alt_val: 8'h00, analog_sel: 8'h00};
    end
    func[0].alt_en[3] = freq_divider_output_en_in; // R12
    func[0].alt_val[3] = freq_divider_output_in;
    func[3].alt_en[3:0] = pwm_en_in; // R13
    func[3].alt_val[3:0] = pwm_in;
    func[1].analog_sel = converter_control_sel_in; // R14
  end

  // One pin driver per port
  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++)
    begin : g_port
      gpio_pin_port u_port (
        .data_latch_in(data_q[gp]),
        .dir_in(dir_q[gp]),
        .pull_sel_in(pull_q[gp]),
        .open_drain_in((gp == 0) ? {4'h0, misc_q[7:OD_FIELD_LSB]} : 8'h00),
        .func_in(func[gp]),
        .pin_in(pin_in[gp*8 +: 8]),
        .drive_out(drive[gp]),
        .read_out(port_read[gp])
      );
      assign pin_out[gp*8 +: 8] = drive[gp].out; // R1
      assign pin_oe_n_out[gp*8 +: 8] = drive[gp].oe_n;
      assign pin_pull_out[gp*8 +: 8] = drive[gp].pull;
    end
  endgenerate

  // ****************************************************************
  // Register read path
  // ****************************************************************

  // Port reads are combinational so the live pin is seen at read time
  always_comb
  begin
    if (reg_addr_in <= REG_PORT_D_DATA)
      read_mux = port_read[reg_addr_in[1:0]]; // R2 R9
    else if (reg_addr_in <= REG_PORT_D_DIR)
      read_mux = dir_q[reg_addr_in[1:0]];
    else if (reg_addr_in <= REG_PORT_D_PULL)
      read_mux = pull_q[reg_addr_in[1:0]];
    else if (reg_addr_in == REG_PORT_A_WAKE)
      read_mux = wake_en_q;
    else if (reg_addr_in == REG_MISC_WDT_OD)
      read_mux = misc_q;
    else
      read_mux = READ_UNMAPPED;
    reg_rdata_out = reg_rd_in ? read_mux : READ_UNMAPPED;
  end

  // ****************************************************************
  // Register write path
  // ****************************************************************

  // Bit ops merge into the read-back of the whole register
  always_comb
  begin
    wr_value = reg_wdata_in;
    if (reg_bitop_in)
    begin
      wr_value = read_mux; // R16
      wr_value[reg_bitsel_in] = reg_bitval_in;
    end
    wr_any = reg_wr_in | reg_bitop_in;
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      data_d[p] = data_q[p]; // R3
      dir_d[p] = dir_q[p];
      pull_d[p] = pull_q[p];
      if (wr_any && reg_addr_in == REG_PORT_A_DATA + 5'(p))
        data_d[p] = wr_value;
      if (wr_any && reg_addr_in == REG_PORT_A_DIR + 5'(p))
        dir_d[p] = wr_value; // R8
      if (wr_any && reg_addr_in == REG_PORT_A_PULL + 5'(p))
        pull_d[p] = wr_value; // R4
    end
    wake_en_d = (wr_any && reg_addr_in == REG_PORT_A_WAKE) ? wr_value : wake_en_q;
    misc_d = (wr_any && reg_addr_in == REG_MISC_WDT_OD) ? wr_value : misc_q; // R6
  end

  // Lower nibble handed to the watchdog untouched
  assign wdt_ctrl_out = misc_q[WDT_FIELD_LSB +: 4]; // R7

  // ****************************************************************
  // Wake-up detection
  // ****************************************************************

  // Falling edge seen against last cycle's pin level; held while powered down
  always_comb
  begin
    pa_prev_d = pin_in[7:0]; // R18
    wake_d = power_down_in & (wake_q | (|(pa_prev_q & ~pin_in[7:0] & wake_en_q))); // R5
  end
  assign wakeup_out = wake_q;

  // Register state, reset to power-on defaults
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      for (int p = 0; p < PORT_COUNT; p++)
      begin
        data_q[p] <= DATA_RESET; // R15
        dir_q[p] <= DIR_RESET;
        pull_q[p] <= PULL_RESET;
      end
      wake_en_q <= WAKE_RESET;
      misc_q <= MISC_RESET;
    end
    else
    begin
      data_q <= data_d;
      dir_q <= dir_d;
      pull_q <= pull_d;
      wake_en_q <= wake_en_d;
      misc_q <= misc_d;
    end
  end

  // Wake state; previous level starts low so leaving reset never fakes a fall
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      pa_prev_q <= 8'h00;
      wake_q <= 1'b0;
    end
    else
    begin
      pa_prev_q <= pa_prev_d;
      wake_q <= wake_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_reset_all_ones: assert property (@(posedge sys_clk_in) // R15
    $past(rst_in) && !rst_in |-> (data_q[0] == DATA_RESET && dir_q[3] == DIR_RESET))
    else $error("ports not all ones after reset");
  chk_latch_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R3
    !$past(reg_wr_in) && !$past(reg_bitop_in) |-> $stable(data_q[2]))
    else $error("data latch changed without write");
  chk_output_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R9
    reg_rd_in && reg_addr_in == REG_PORT_C_DATA && dir_q[2] == 8'h00 |->
    reg_rdata_out == data_q[2])
    else $error("output read not from latch");
  chk_input_direct: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R2
    reg_rd_in && reg_addr_in == REG_PORT_B_DATA && dir_q[1] == 8'hFF |->
    reg_rdata_out == pin_in[15:8])
    else $error("input read not from pin");
  chk_input_undriven: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R8
    dir_q[1][0] |-> pin_oe_n_out[8])
    else $error("input pin driven");
  chk_pull_inputs: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R4
    pin_pull_out[16] |-> dir_q[2][0] && pull_q[2][0])
    else $error("pull-high on output");
  chk_analog_nopull: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R14
    converter_control_sel_in[2] |-> !pin_pull_out[10])
    else $error("pull-high on analog pin");
  chk_open_drain: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R17
    misc_q[4] && !dir_q[0][0] && data_q[0][0] |-> pin_oe_n_out[0])
    else $error("open drain drove high");
  chk_pwm_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R13
    pwm_en_in[1] && !dir_q[3][1] |-> pin_out[25] == pwm_in[1] && !pin_oe_n_out[25])
    else $error("pwm not on output pin");
  // Enabled port A pin 0 high, then low, both while powered down
  sequence s_pa0_high;
    power_down_in && wake_en_q[0] && pin_in[0];
  endsequence
  sequence s_pa0_low;
    power_down_in && wake_en_q[0] && !pin_in[0];
  endsequence
  chk_wake_edge: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R5
    s_pa0_high ##1 s_pa0_low |=> wakeup_out)
    else $error("falling edge missed");
  chk_wake_awake: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R18
    !$past(power_down_in) |-> !wakeup_out)
    else $error("wake flagged while running");

  // Writes land on the next edge
  chk_data_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R3
    reg_wr_in && !reg_bitop_in && reg_addr_in == REG_PORT_A_DATA |=>
    data_q[0] == $past(reg_wdata_in))
    else $error("data write lost");
  chk_dir_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R8
    reg_wr_in && !reg_bitop_in && reg_addr_in == REG_PORT_A_DIR |=>
    dir_q[0] == $past(reg_wdata_in))
    else $error("direction write lost");
  chk_bit_rmw: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R16
    reg_bitop_in && reg_addr_in == REG_PORT_C_DATA |=>
    data_q[2][$past(reg_bitsel_in)] == $past(reg_bitval_in))
    else $error("bit operation did not land");
  chk_wdt_field: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R7
    reg_wr_in && !reg_bitop_in && reg_addr_in == REG_MISC_WDT_OD |=>
    wdt_ctrl_out == $past(reg_wdata_in[3:0]))
    else $error("watchdog bits not passed on");

  // Shared functions and open drain at the pin
  chk_pfd_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R12
    freq_divider_output_en_in && !dir_q[0][3] && !misc_q[7] |->
    pin_out[3] == freq_divider_output_in && !pin_oe_n_out[3])
    else $error("divider not on output pin");
  chk_pfd_input: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R12
    freq_divider_output_en_in && dir_q[0][3] |-> pin_oe_n_out[3])
    else $error("divider drove an input pin");
  chk_od_drive_low: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R17
    misc_q[4] && !dir_q[0][0] && !data_q[0][0] |-> !pin_oe_n_out[0] && !pin_out[0])
    else $error("open drain failed to pull low");

  // Wake flag holds while still powered down
  chk_wake_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // R5
    wakeup_out && power_down_in |=> wakeup_out)
    else $error("wake flag dropped in power-down");

endmodule : general_io_ports

//--- rtl/gpio_pkg.sv
// Package with register indices, reset values and carrier types for the I/O ports
package gpio_pkg;

  // ****************************************************************
  // Register selection
  // ****************************************************************
  localparam logic [4:0] REG_PORT_A_DATA = 5'h00;
  localparam logic [4:0] REG_PORT_B_DATA = 5'h01;
  localparam logic [4:0] REG_PORT_C_DATA = 5'h02;
  localparam logic [4:0] REG_PORT_D_DATA = 5'h03;
  localparam logic [4:0] REG_PORT_A_DIR = 5'h04;
  localparam logic [4:0] REG_PORT_B_DIR = 5'h05;
  localparam logic [4:0] REG_PORT_C_DIR = 5'h06;
  localparam logic [4:0] REG_PORT_D_DIR = 5'h07;
  localparam logic [4:0] REG_PORT_A_PULL = 5'h08;
  localparam logic [4:0] REG_PORT_B_PULL = 5'h09;
  localparam logic [4:0] REG_PORT_C_PULL = 5'h0A;
  localparam logic [4:0] REG_PORT_D_PULL = 5'h0B;
  localparam logic [4:0] REG_PORT_A_WAKE = 5'h0C;
  localparam logic [4:0] REG_MISC_WDT_OD = 5'h0D;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int OD_FIELD_LSB = 4;
  localparam int WDT_FIELD_LSB = 0;
  localparam int PORT_COUNT = 4;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Pin-shared function requests for one port
  typedef struct packed {
    logic [7:0] alt_en;
    logic [7:0] alt_val;
    logic [7:0] analog_sel;
  } pin_func_t;

  // Three-signal pin group for one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull;
  } pin_drive_t;

endpackage : gpio_pkg

//--- rtl/gpio_pin_port.sv
// One 8-bit port: pin driver, pull-high gating and read-back selection
`timescale 1ns/1ps
module gpio_pin_port
  import gpio_pkg::*;
(
  // Port configuration
  input wire logic [7:0] data_latch_in,
  input wire logic [7:0] dir_in,
  input wire logic [7:0] pull_sel_in,
  input wire logic [7:0] open_drain_in,
  input wire pin_func_t func_in,
  // Pin side
  input wire logic [7:0] pin_in,
  output pin_drive_t drive_out,
  output logic [7:0] read_out
);

  logic [7:0] level;

  // Output level and drive enable per pin
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      // Shared function only reaches the pin when direction is output
      level[i] = func_in.alt_en[i] ? func_in.alt_val[i] : data_latch_in[i]; // R12 R13
      drive_out.out[i] = level[i];
      if (dir_in[i]) // R8
        drive_out.oe_n[i] = 1'b1;
      else if (open_drain_in[i] && level[i]) // R17
        drive_out.oe_n[i] = 1'b1;
      else
        drive_out.oe_n[i] = 1'b0; // R6
      // Pull-high only on inputs, and never on analog-selected pins
      drive_out.pull[i] = pull_sel_in[i] & dir_in[i] & ~func_in.analog_sel[i]; // R4 R14
      // Inputs read the raw pin, outputs read the latch
      read_out[i] = dir_in[i] ? pin_in[i] : data_latch_in[i]; // R2 R9 R11
    end
  end

endmodule : gpio_pin_port

//--- verif/pin_partner.sv
// Model of the external circuitry that sits on the 32 port pins
`timescale 1ns/1ps
module pin_partner
(
  // Clock
  input wire logic sys_clk_in,
  // Device side
  input wire logic [31:0] pin_out_in,
  input wire logic [31:0] pin_oe_n_in,
  input wire logic [31:0] pin_pull_in,
  // Bench control of the outside drivers
  input wire logic [31:0] ext_val_in,
  input wire logic [31:0] ext_en_in,
  output logic [31:0] level_out
);
  logic [31:0] float_q = 32'h00000000;

  // Floating pins toggle so a stale level is never mistaken for a real one
  always @(posedge sys_clk_in)
    float_q <= ~float_q;

  // Wire level worked out from every party's enable
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (!pin_oe_n_in[i])
        level_out[i] = pin_out_in[i];
      else if (ext_en_in[i])
        level_out[i] = ext_val_in[i];
      else if (pin_pull_in[i])
        level_out[i] = 1'b1;
      else
        level_out[i] = float_q[i];
    end
  end
endmodule : pin_partner

//--- verif/test_general_io_ports.sv
// Self-checking testbench for the four general I/O ports
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_general_io_ports;
  import gpio_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0, rd = 1'b0, bitop = 1'b0, bitval = 1'b0;
  logic [2:0] bitsel = 3'h0;
  logic [7:0] wdata = 8'h00, conv = 8'h00;
  logic [7:0] rdata;
  logic fd_en = 1'b0, fd_val = 1'b0, pd = 1'b0;
  logic [3:0] pwm_en = 4'h0, pwm = 4'h0, wdt;
  logic wake;
  logic [31:0] ext_val = 32'h00000000, ext_en = 32'h00000000;
  logic [31:0] pin_lvl, pout, poe_n, ppull;
  int fails = 0;
  int checks_done = 0;

  // Clock at 50 MHz
  always #10 sys_clk_in = ~sys_clk_in;

  general_io_ports u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_bitop_in(bitop),
    .reg_bitval_in(bitval), .reg_bitsel_in(bitsel), .reg_rdata_out(rdata),
    .freq_divider_output_en_in(fd_en), .freq_divider_output_in(fd_val),
    .pwm_en_in(pwm_en), .pwm_in(pwm), .converter_control_sel_in(conv),
    .power_down_in(pd), .wakeup_out(wake), .wdt_ctrl_out(wdt), .pin_in(pin_lvl),
    .pin_out(pout), .pin_oe_n_out(poe_n), .pin_pull_out(ppull));

  pin_partner u_pins (.sys_clk_in(sys_clk_in), .pin_out_in(pout), .pin_oe_n_in(poe_n),
    .pin_pull_in(ppull), .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pin_lvl));

  // ****************************************************************
  // Register access, driven on the falling edge
  // ****************************************************************
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge sys_clk_in) {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge sys_clk_in) wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
    @(negedge sys_clk_in) {addr, rd} = {a, 1'b1};
    #1 `CHK(nm, e, rdata)
    @(negedge sys_clk_in) rd = 1'b0;
  endtask : rd_chk

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // All pins come up as inputs, so port reads show what the outside drives
  task automatic t_reset;
    ext_val = 32'h30C3A55A;
    ext_en = 32'hFFFFFFFF;
    for (int i = 0; i < 4; i++)
    begin
      rd_chk("data", REG_PORT_A_DATA + 5'(i), ext_val[i*8 +: 8]);
      rd_chk("dir", REG_PORT_A_DIR + 5'(i), 8'hFF);
    end
    ext_val[29:28] = 2'b01;
    rd_chk("irq_pins", REG_PORT_D_DATA, 8'h10);
    rd_chk("unmapped", 5'h1F, 8'h00);
    `CHK("oe_n", 32'hFFFFFFFF, poe_n)
    `CHK("pout", 32'hFFFFFFFF, pout)
  endtask : t_reset

  // Output latch read back while the outside fights it; inputs read live
  task automatic t_latch;
    ext_val = 32'h00003CAA;
    ext_en = 32'h0000FFFF;
    wr_reg(REG_PORT_A_DIR, 8'h00);
    wr_reg(REG_PORT_A_DATA, 8'h55);
    rd_chk("a_rd", REG_PORT_A_DATA, 8'h55);
    `CHK("a_oe", 8'h00, poe_n[7:0])
    wr_reg(REG_PORT_C_DATA, 8'h12);
    `CHK("a_held", 8'h55, pout[7:0])
    rd_chk("b_live", REG_PORT_B_DATA, 8'h3C);
    ext_val[15:8] = 8'hC3;
    rd_chk("b_live2", REG_PORT_B_DATA, 8'hC3);
  endtask : t_latch

  task automatic t_pull;
    ext_en = 32'h00000000;
    conv = 8'h0F;
    wr_reg(REG_PORT_B_PULL, 8'hFF);
    wr_reg(REG_PORT_C_DIR, 8'h0F);
    wr_reg(REG_PORT_C_PULL, 8'hFF);
    #1 `CHK("b_pull", 8'hF0, ppull[15:8])
    `CHK("c_pull", 8'h0F, ppull[23:16])
  endtask : t_pull

  // Read-modify-write mixes live input levels into the latch
  task automatic t_bitop;
    wr_reg(REG_PORT_C_DATA, 8'h00);
    ext_val[23:16] = 8'h05;
    ext_en[23:16] = 8'h0F;
    @(negedge sys_clk_in) {addr, bitsel, bitval, bitop} = {REG_PORT_C_DATA, 3'h7, 2'b11};
    @(negedge sys_clk_in) bitop = 1'b0;
    wr_reg(REG_PORT_C_DIR, 8'h00);
    rd_chk("c_rmw", REG_PORT_C_DATA, 8'h85);
  endtask : t_bitop

  task automatic t_shared;
    {fd_en, fd_val, pwm_en, pwm} = {2'b10, 4'hF, 4'h5};
    wr_reg(REG_PORT_A_DATA, 8'hFF);
    wr_reg(REG_PORT_D_DIR, 8'h00);
    #1 `CHK("pfd", 1'b0, pout[3])
    `CHK("pwm", 4'h5, pout[27:24])
    wr_reg(REG_PORT_A_DIR, 8'h08);
    wr_reg(REG_PORT_D_DIR, 8'h0F);
    #1 `CHK("pfd_in", 1'b1, poe_n[3])
    `CHK("pwm_in", 4'hF, poe_n[27:24])
    @(negedge sys_clk_in) fd_en = 1'b0;
    pwm_en = 4'h0;
  endtask : t_shared

  task automatic t_odrain;
    wr_reg(REG_MISC_WDT_OD, 8'hB6);
    rd_chk("misc", REG_MISC_WDT_OD, 8'hB6);
    `CHK("wdt", 4'h6, wdt)
    wr_reg(REG_PORT_A_DIR, 8'h00);
    wr_reg(REG_PORT_A_DATA, 8'h0F);
    #1 `CHK("od_one", 8'h0B, poe_n[7:0])
    wr_reg(REG_PORT_A_DATA, 8'h00);
    #1 `CHK("od_zero", 8'h00, poe_n[7:0])
    `CHK("od_low", 4'h0, pout[3:0])
  endtask : t_odrain

  // Only an enabled pin falling in power-down wakes, flag drops with it
  task automatic t_wake;
    wr_reg(REG_PORT_A_DIR, 8'hFF);
    ext_val[7:0] = 8'hFF;
    ext_en[7:0] = 8'hFF;
    wr_reg(REG_PORT_A_WAKE, 8'h01);
    pd = 1'b1;
    @(negedge sys_clk_in) ext_val[1] = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK("wake_off", 1'b0, wake)
    ext_val[0] = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK("wake_on", 1'b1, wake)
    @(negedge sys_clk_in) pd = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    `CHK("wake_clr", 1'b0, wake)
  endtask : t_wake

  // Watchdog against a hang
  initial
  begin
    #100us;
    fails++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_reset();
    t_latch();
    t_pull();
    t_bitop();
    t_shared();
    t_odrain();
    t_wake();
    results();
  end
endmodule : test_general_io_ports
